// [core/tsa_lfsr.sv]
// Free-running pseudo-random source for the tag handle.
// Assumes an entropy bit that differs between tags; it is folded into the feedback.
`timescale 1ns/1ps
`default_nettype none
module tsa_lfsr (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic entropy_bit,
    output logic [tsa_pkg::HANDLE_W-1:0] random_byte
);
    import tsa_pkg::*;

    logic [LFSR_W-1:0] shift;
    logic [LFSR_W-1:0] next_shift;

    // Galois step with the entropy bit mixed into the feedback
    always_comb begin
        next_shift = {1'b0, shift[LFSR_W-1:1]};
        if (shift[0] ^ entropy_bit) begin
            next_shift = next_shift ^ LFSR_TAPS;
        end
        if (next_shift == '0) begin
            next_shift = LFSR_SEED; // Never stick at all zeros
        end
    end

    // Advance every cycle so each tag drifts on its own
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            shift <= LFSR_SEED;
        end else begin
            shift <= next_shift;
        end
    end

    assign random_byte = shift[HANDLE_W-1:0];

    a_lfsr_nonzero: assert property (@(posedge clock) disable iff (!rst_b)
        shift != '0) else $error("random source stuck at zero");
endmodule // tsa_lfsr
`default_nettype wire

// [core/tsa_pkg.sv]
// Constants, state and command codes for the tag state and anticollision block.
// Assumes an upstream frame decoder that hands over one checked command per pulse.
`default_nettype none
package tsa_pkg;
    localparam int HANDLE_W = 8;
    localparam int NIBBLE_W = 4;
    localparam int LFSR_W = 16;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [7:0] HANDLE_RESET = 8'h00;

    // One-hot tag states
    typedef enum logic [5:0] {
        TSA_OFF = 6'h01,
        TSA_READY = 6'h02,
        TSA_INVENTORY = 6'h04,
        TSA_SELECTED = 6'h08,
        TSA_DESELECTED = 6'h10,
        TSA_DEACTIVATED = 6'h20
    } tsa_state_t;

    // Decoded reader commands
    typedef enum logic [3:0] {
        TSA_CMD_NONE = 4'h0,
        TSA_CMD_INVENTORY_OPEN = 4'h1,
        TSA_CMD_SLOT_ZERO_PROBE = 4'h2,
        TSA_CMD_SLOT_PROBE = 4'h3,
        TSA_CMD_SELECT = 4'h4,
        TSA_CMD_READ_BLOCK = 4'h5,
        TSA_CMD_WRITE_BLOCK = 4'h6,
        TSA_CMD_AUTHENTICATE = 4'h7,
        TSA_CMD_UNIQUE_ID_READ = 4'h8,
        TSA_CMD_DEACTIVATE = 4'h9
    } tsa_cmd_t;
endpackage : tsa_pkg
`default_nettype wire

// [core/tsa_reply.sv]
// Answer register: flags the handle reply for one cycle toward the encoder and keeps the handle until the next load.
// Assumes the encoder captures the handle on the cycle that reply_valid is high.
`timescale 1ns/1ps
`default_nettype none
module tsa_reply (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic reply_load,
    input wire logic [tsa_pkg::HANDLE_W-1:0] reply_data,
    output logic reply_valid,
    output logic [tsa_pkg::HANDLE_W-1:0] reply_handle
);
    import tsa_pkg::*;

    logic next_reply_valid;
    logic [HANDLE_W-1:0] next_reply_handle;

    // Capture on load, keep last handle otherwise
    always_comb begin
        next_reply_valid = reply_load;
        next_reply_handle = reply_load ? reply_data : reply_handle;
    end

    // Register the answer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reply_valid <= 1'b0;
            reply_handle <= HANDLE_RESET;
        end else begin
            reply_valid <= next_reply_valid;
            reply_handle <= next_reply_handle;
        end
    end

    a_reply_data_held: assert property (@(posedge clock) disable iff (!rst_b)
        reply_load |=> reply_valid && reply_handle == $past(reply_data))
        else $error("reply handle not captured");
endmodule // tsa_reply
`default_nettype wire

// [core/tsa_tag_ctrl.sv]
// Tag state controller and anticollision responder.
// Assumes field_ok and the command strobe are synchronous to clock and that a
// command pulse lasts one cycle with its code and arguments valid alongside.
`timescale 1ns/1ps
`default_nettype none
module tsa_tag_ctrl (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic field_ok,
    input wire logic entropy_bit,
    input wire logic cmd_valid,
    input wire tsa_pkg::tsa_cmd_t cmd_code,
    input wire logic [tsa_pkg::HANDLE_W-1:0] cmd_handle,
    input wire logic [tsa_pkg::NIBBLE_W-1:0] probe_slot_index,
    output logic reply_valid,
    output logic [tsa_pkg::HANDLE_W-1:0] reply_handle,
    output logic access_valid,
    output tsa_pkg::tsa_cmd_t access_cmd,
    output tsa_pkg::tsa_state_t tag_state,
    output logic [tsa_pkg::HANDLE_W-1:0] tag_handle
);
    import tsa_pkg::*;

    tsa_state_t next_tag_state;
    logic [HANDLE_W-1:0] next_tag_handle;
    logic [HANDLE_W-1:0] random_byte;
    logic replied;
    logic next_replied;
    logic next_access_valid;
    tsa_cmd_t next_access_cmd;
    logic reply_load;
    logic [HANDLE_W-1:0] reply_data;
    logic take;
    logic handle_match;
    logic [NIBBLE_W-1:0] slot_nibble;
    logic [NIBBLE_W-1:0] fresh_nibble;

    // Random source, free running
    tsa_lfsr u_lfsr (
        .clock(clock),
        .rst_b(rst_b),
        .entropy_bit(entropy_bit),
        .random_byte(random_byte)
    );

    // Answer register toward the encoder
    tsa_reply u_reply (
        .clock(clock),
        .rst_b(rst_b),
        .reply_load(reply_load),
        .reply_data(reply_data),
        .reply_valid(reply_valid),
        .reply_handle(reply_handle)
    );

    // Command qualifiers
    assign take = cmd_valid && field_ok;
    assign handle_match = (cmd_handle == tag_handle);
    assign slot_nibble = tag_handle[NIBBLE_W-1:0];
    assign fresh_nibble = random_byte[NIBBLE_W-1:0];

    // Next state, handle, reply and access strobe
    always_comb begin
        next_tag_state = tag_state;
        next_tag_handle = tag_handle;
        next_replied = replied;
        next_access_valid = 1'b0;
        next_access_cmd = access_cmd;
        reply_load = 1'b0;
        reply_data = tag_handle;
        if (!field_ok) begin
            next_tag_state = TSA_OFF;
            next_replied = 1'b0;
        end else begin
            case (tag_state)
                TSA_OFF: begin
                    next_tag_state = TSA_READY;
                    next_tag_handle = random_byte;
                    next_replied = 1'b0;
                end
                TSA_READY: begin
                    if (take && cmd_code == TSA_CMD_INVENTORY_OPEN) begin
                        next_tag_state = TSA_INVENTORY;
                        next_tag_handle = random_byte;
                        reply_load = 1'b1;
                        reply_data = random_byte;
                        next_replied = 1'b0;
                    end
                end
                TSA_INVENTORY: begin
                    if (take) begin
                        case (cmd_code)
                            TSA_CMD_INVENTORY_OPEN: begin
                                next_tag_handle = random_byte;
                                reply_load = 1'b1;
                                reply_data = random_byte;
                                next_replied = 1'b0;
                            end
                            TSA_CMD_SLOT_ZERO_PROBE: begin
                                next_tag_handle = {tag_handle[HANDLE_W-1:NIBBLE_W],
                                                   fresh_nibble};
                                reply_load = (fresh_nibble == NIBBLE_ZERO);
                                reply_data = {tag_handle[HANDLE_W-1:NIBBLE_W], fresh_nibble};
                                next_replied = (fresh_nibble == NIBBLE_ZERO);
                            end
                            TSA_CMD_SLOT_PROBE: begin
                                if (probe_slot_index != NIBBLE_ZERO
                                        && probe_slot_index == slot_nibble
                                        && !replied) begin
                                    reply_load = 1'b1;
                                    next_replied = 1'b1;
                                end
                            end
                            TSA_CMD_SELECT: begin
                                if (handle_match) begin
                                    next_tag_state = TSA_SELECTED;
                                end
                            end
                            default: begin
                                next_tag_state = TSA_INVENTORY;
                            end
                        endcase
                    end
                end
                TSA_SELECTED: begin
                    if (take) begin
                        case (cmd_code)
                            TSA_CMD_READ_BLOCK,
                            TSA_CMD_WRITE_BLOCK,
                            TSA_CMD_AUTHENTICATE,
                            TSA_CMD_UNIQUE_ID_READ: begin
                                next_access_valid = 1'b1;
                                next_access_cmd = cmd_code;
                            end
                            TSA_CMD_SELECT: begin
                                if (!handle_match) begin
                                    next_tag_state = TSA_DESELECTED;
                                end
                            end
                            TSA_CMD_DEACTIVATE: begin
                                next_tag_state = TSA_DEACTIVATED;
                            end
                            default: begin
                                next_tag_state = TSA_SELECTED;
                            end
                        endcase
                    end
                end
                TSA_DESELECTED: begin
                    if (take && cmd_code == TSA_CMD_SELECT && handle_match) begin
                        next_tag_state = TSA_SELECTED;
                    end
                end
                TSA_DEACTIVATED: begin
                    next_tag_state = TSA_DEACTIVATED;
                end
                default: begin
                    next_tag_state = TSA_OFF;
                end
            endcase
        end
    end

    // Register the tag state, handle and access strobe
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tag_state <= TSA_OFF;
            tag_handle <= HANDLE_RESET;
            replied <= 1'b0;
            access_valid <= 1'b0;
            access_cmd <= TSA_CMD_NONE;
        end else begin
            tag_state <= next_tag_state;
            tag_handle <= next_tag_handle;
            replied <= next_replied;
            access_valid <= next_access_valid;
            access_cmd <= next_access_cmd;
        end
    end

    // Checking helpers: probe replies since the last round start
    logic [1:0] round_replies;
    logic [1:0] next_round_replies;
    logic round_start;
    logic probe_reply;

    assign round_start = take && tag_state == TSA_INVENTORY
        && (cmd_code == TSA_CMD_SLOT_ZERO_PROBE || cmd_code == TSA_CMD_INVENTORY_OPEN);
    assign probe_reply = reply_load && cmd_code == TSA_CMD_SLOT_PROBE;

    // Count replies in the current round, saturating
    always_comb begin
        next_round_replies = round_replies;
        if (!field_ok) begin
            next_round_replies = 2'h0;
        end else if (round_start) begin
            next_round_replies = {1'b0, reply_load && cmd_code == TSA_CMD_SLOT_ZERO_PROBE};
        end else if (probe_reply && round_replies != 2'h3) begin
            next_round_replies = round_replies + 2'h1;
        end
    end

    // Register the reply count
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            round_replies <= 2'h0;
        end else begin
            round_replies <= next_round_replies;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // Sequences for multi-step checks
    sequence s_cmd(tsa_state_t st, tsa_cmd_t c);
        tag_state == st && take && cmd_code == c;
    endsequence

    sequence s_power_up;
        tag_state == TSA_OFF && field_ok;
    endsequence

    a_off_silent: assert property (
        !field_ok |=> tag_state == TSA_OFF ##1 !reply_valid && !access_valid)
        else $error("tag active in weak field");

    a_power_ready: assert property (
        s_power_up |=> tag_state == TSA_READY && tag_handle == $past(random_byte))
        else $error("power-up did not enter ready with random handle");

    a_ready_ignores: assert property (
        tag_state == TSA_READY && field_ok && !(take && cmd_code == TSA_CMD_INVENTORY_OPEN)
        |=> tag_state == TSA_READY && !reply_valid)
        else $error("ready tag reacted to a command");

    a_ready_open: assert property (
        s_cmd(TSA_READY, TSA_CMD_INVENTORY_OPEN) |=> tag_state == TSA_INVENTORY)
        else $error("inventory-open did not enter inventory");

    a_inv_stays: assert property (
        tag_state == TSA_INVENTORY && take && cmd_code != TSA_CMD_SELECT && field_ok
        |=> tag_state == TSA_INVENTORY)
        else $error("inventory left on an anticollision command");

    a_select_match: assert property (
        s_cmd(TSA_INVENTORY, TSA_CMD_SELECT) |=>
        tag_state == ($past(handle_match) ? TSA_SELECTED : TSA_INVENTORY))
        else $error("select in inventory took the wrong branch");

    a_access_strobe: assert property (
        tag_state == TSA_SELECTED && take && (cmd_code == TSA_CMD_READ_BLOCK
        || cmd_code == TSA_CMD_UNIQUE_ID_READ) |=> access_valid && access_cmd == $past(cmd_code))
        else $error("access command not forwarded");

    a_sel_no_anticoll: assert property (
        tag_state == TSA_SELECTED ##1 reply_valid |-> 0)
        else $error("selected tag answered an anticollision command");

    a_sel_deselect: assert property (
        s_cmd(TSA_SELECTED, TSA_CMD_SELECT) ##0 !handle_match |=> tag_state == TSA_DESELECTED)
        else $error("mismatching select did not deselect");

    a_sel_deactivate: assert property (
        s_cmd(TSA_SELECTED, TSA_CMD_DEACTIVATE) |=> tag_state == TSA_DEACTIVATED)
        else $error("deactivate command ignored");

    a_desel_return: assert property (
        tag_state == TSA_DESELECTED && field_ok |=>
        tag_state == ($past(take && cmd_code == TSA_CMD_SELECT && handle_match)
        ? TSA_SELECTED : TSA_DESELECTED))
        else $error("deselected tag changed state wrongly");

    a_deact_hold: assert property (
        tag_state == TSA_DEACTIVATED && field_ok |=> tag_state == TSA_DEACTIVATED
        && !access_valid && !reply_valid)
        else $error("deactivated tag left its state");

    a_open_reply: assert property (
        s_cmd(TSA_INVENTORY, TSA_CMD_INVENTORY_OPEN) |=> reply_valid
        && reply_handle == tag_handle && tag_handle == $past(random_byte))
        else $error("inventory-open reply missing or handle not renewed");

    a_zero_probe: assert property (
        s_cmd(TSA_INVENTORY, TSA_CMD_SLOT_ZERO_PROBE) |=>
        tag_handle[NIBBLE_W-1:0] == $past(fresh_nibble)
        && reply_valid == (tag_handle[NIBBLE_W-1:0] == NIBBLE_ZERO))
        else $error("slot-zero probe nibble or reply wrong");

    a_slot_probe: assert property (
        s_cmd(TSA_INVENTORY, TSA_CMD_SLOT_PROBE) ##0 !replied |=>
        reply_valid == ($past(probe_slot_index) != NIBBLE_ZERO
        && $past(probe_slot_index) == $past(slot_nibble)))
        else $error("slot probe reply does not follow nibble match");

    a_once_round: assert property (
        round_replies <= 2'h1)
        else $error("more than one reply in a round");

    a_ready_no_access: assert property (
        tag_state == TSA_READY |=> !access_valid)
        else $error("ready tag forwarded an access");

    a_probe_zero_idx: assert property (
        s_cmd(TSA_INVENTORY, TSA_CMD_SLOT_PROBE) ##0 probe_slot_index == NIBBLE_ZERO
        |=> !reply_valid)
        else $error("slot probe with index zero answered");

    a_probe_silent: assert property (
        s_cmd(TSA_INVENTORY, TSA_CMD_SLOT_PROBE) ##0 replied |=> !reply_valid)
        else $error("second reply in one round");

    a_sel_match_stays: assert property (
        s_cmd(TSA_SELECTED, TSA_CMD_SELECT) ##0 handle_match |=> tag_state == TSA_SELECTED)
        else $error("matching select left selected state");

    a_sel_keeps_state: assert property (
        tag_state == TSA_SELECTED && take && (cmd_code == TSA_CMD_INVENTORY_OPEN
        || cmd_code == TSA_CMD_SLOT_ZERO_PROBE || cmd_code == TSA_CMD_SLOT_PROBE)
        |=> tag_state == TSA_SELECTED && $stable(tag_handle) && !access_valid)
        else $error("selected tag reacted to anticollision");

    a_access_only_sel: assert property (
        access_valid |-> $past(tag_state) == TSA_SELECTED)
        else $error("access strobe outside selected state");

    a_access_all: assert property (
        tag_state == TSA_SELECTED && take && (cmd_code == TSA_CMD_WRITE_BLOCK
        || cmd_code == TSA_CMD_AUTHENTICATE)
        |=> access_valid && access_cmd == $past(cmd_code))
        else $error("write or authenticate not forwarded");

    a_reply_source: assert property (
        reply_valid |-> $past(tag_state) == TSA_INVENTORY || $past(tag_state) == TSA_READY)
        else $error("reply from a silent state");

    a_desel_silent: assert property (
        tag_state == TSA_DESELECTED |=> !reply_valid && !access_valid)
        else $error("deselected tag answered");

    a_handle_held: assert property (
        tag_state == TSA_SELECTED || tag_state == TSA_DESELECTED
        || tag_state == TSA_DEACTIVATED |=> $stable(tag_handle))
        else $error("handle changed outside inventory");

    a_field_drop: assert property (
        !field_ok |=> !reply_valid && !access_valid)
        else $error("answer while field weak");

    a_zero_handle: assert property (
        s_cmd(TSA_INVENTORY, TSA_CMD_SLOT_ZERO_PROBE) ##0 fresh_nibble == NIBBLE_ZERO
        |=> reply_handle == tag_handle)
        else $error("slot-zero reply lacks full handle");

    a_probe_handle: assert property (
        s_cmd(TSA_INVENTORY, TSA_CMD_SLOT_PROBE) |=> $stable(tag_handle)
        && (!reply_valid || reply_handle == tag_handle))
        else $error("slot probe handle wrong");
endmodule // tsa_tag_ctrl
`default_nettype wire

// [dv/tb_tag_state_and_anticollision.sv]
// Self-checking bench for the tag state controller and anticollision responder.
// Assumes the reader model sits on the command side and the bench owns field and entropy.
`timescale 1ns/1ps
`default_nettype none
module tb_tag_state_and_anticollision;
    import tsa_pkg::*;

    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic field_ok = 1'b0;
    logic entropy_bit = 1'b0;
    logic cmd_valid;
    tsa_cmd_t cmd_code;
    logic [HANDLE_W-1:0] cmd_handle;
    logic [NIBBLE_W-1:0] probe_slot_index;
    logic reply_valid;
    logic [HANDLE_W-1:0] reply_handle;
    logic access_valid;
    tsa_cmd_t access_cmd;
    tsa_state_t tag_state;
    logic [HANDLE_W-1:0] tag_handle;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int acc_n = 0;

    tsa_tag_ctrl uut (.clock(clock), .rst_b(rst_b), .field_ok(field_ok),
        .entropy_bit(entropy_bit), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_handle(cmd_handle), .probe_slot_index(probe_slot_index),
        .reply_valid(reply_valid), .reply_handle(reply_handle), .access_valid(access_valid),
        .access_cmd(access_cmd), .tag_state(tag_state), .tag_handle(tag_handle));

    tsa_reader_model rdr (.clock(clock), .reply_valid(reply_valid),
        .reply_handle(reply_handle), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_handle(cmd_handle), .probe_slot_index(probe_slot_index));

    // 40 MHz clock
    always #12.5 clock = ~clock;

    // Entropy pattern, access pulse count and hang guard
    always @(negedge clock) entropy_bit <= cyc[0] ^ cyc[3];
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (access_valid === 1'b1) acc_n <= acc_n + 1;
        if (cyc == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // No reply, no access and the given state since the snapshot
    task automatic expect_idle(input string name, input int r0, input int a0, input tsa_state_t st);
        check({name, " replies"}, 8'(rdr.n_reply - r0), 8'h00);
        check({name, " accesses"}, 8'(acc_n - a0), 8'h00);
        check({name, " state"}, {2'b00, tag_state}, {2'b00, st});
    endtask

    task automatic t_field_off();
        int r0 = rdr.n_reply;
        rdr.send(TSA_CMD_INVENTORY_OPEN, 8'h00, 4'h0);
        expect_idle("weak field", r0, acc_n, TSA_OFF);
    endtask

    task automatic t_power_up();
        int r0;
        int a0;
        @(negedge clock);
        field_ok = 1'b1;
        repeat (2) @(negedge clock);
        check("power up state", {2'b00, tag_state}, {2'b00, TSA_READY});
        r0 = rdr.n_reply;
        a0 = acc_n;
        for (int i = 2; i <= 9; i++) begin
            rdr.send(tsa_cmd_t'(i), tag_handle, 4'h1);
        end
        expect_idle("ready ignores", r0, a0, TSA_READY);
    endtask

    task automatic t_open();
        int r0;
        logic [7:0] h0;
        bit moved = 0;
        r0 = rdr.n_reply;
        rdr.send(TSA_CMD_INVENTORY_OPEN, 8'h00, 4'h0);
        check("open reply", 8'(rdr.n_reply - r0), 8'h01);
        check("open handle", rdr.last_reply, tag_handle);
        check("open state", {2'b00, tag_state}, {2'b00, TSA_INVENTORY});
        h0 = tag_handle;
        for (int i = 0; i < 4; i++) begin
            rdr.send(TSA_CMD_INVENTORY_OPEN, 8'h00, 4'h0);
            if (tag_handle !== h0) moved = 1;
        end
        check("handle reloads", 8'(moved), 8'h01);
        check("reopen state", {2'b00, tag_state}, {2'b00, TSA_INVENTORY});
        r0 = rdr.n_reply;
        rdr.send(TSA_CMD_SLOT_PROBE, 8'h00, 4'h0);
        rdr.send(TSA_CMD_SELECT, tag_handle ^ 8'h80, 4'h0);
        expect_idle("slot 0 probe, bad select", r0, acc_n, TSA_INVENTORY);
    endtask

    task automatic t_rounds();
        int hits;
        int slot;
        rdr.run_round(1'b0, hits, slot);
        check("round hits", 8'(hits), 8'h01);
        check("round slot", 8'(slot), {4'h0, tag_handle[3:0]});
        check("round state", {2'b00, tag_state}, {2'b00, TSA_INVENTORY});
        rdr.run_round(1'b1, hits, slot);
        check("pick round hits", 8'(hits), 8'h01);
        check("pick round slot", 8'(slot), {4'h0, tag_handle[3:0]});
        check("pick state", {2'b00, tag_state}, {2'b00, TSA_SELECTED});
    endtask

    task automatic t_selected();
        int a0;
        int r0;
        for (int i = 5; i <= 8; i++) begin
            a0 = acc_n;
            rdr.send(tsa_cmd_t'(i), 8'h00, 4'h0);
            check("access pulse", 8'(acc_n - a0), 8'h01);
            check("access code", {4'h0, access_cmd}, 8'(i));
        end
        r0 = rdr.n_reply;
        a0 = acc_n;
        rdr.send(TSA_CMD_INVENTORY_OPEN, 8'h00, 4'h0);
        rdr.send(TSA_CMD_SLOT_ZERO_PROBE, 8'h00, 4'h0);
        for (int s = 1; s < 16; s++) rdr.send(TSA_CMD_SLOT_PROBE, 8'h00, 4'(s));
        rdr.send(TSA_CMD_SELECT, tag_handle, 4'h0);
        expect_idle("selected ignores", r0, a0, TSA_SELECTED);
        rdr.send(TSA_CMD_SELECT, tag_handle ^ 8'h01, 4'h0);
        check("deselect", {2'b00, tag_state}, {2'b00, TSA_DESELECTED});
    endtask

    task automatic t_deselected();
        int r0 = rdr.n_reply;
        int a0 = acc_n;
        for (int i = 1; i <= 9; i++) begin
            rdr.send(tsa_cmd_t'(i), tag_handle ^ 8'h10, 4'h1);
        end
        expect_idle("deselected ignores", r0, a0, TSA_DESELECTED);
        rdr.send(TSA_CMD_SELECT, tag_handle, 4'h0);
        check("reselect", {2'b00, tag_state}, {2'b00, TSA_SELECTED});
    endtask

    task automatic t_deactivated();
        int r0;
        int a0;
        rdr.send(TSA_CMD_DEACTIVATE, 8'h00, 4'h0);
        check("deactivate", {2'b00, tag_state}, {2'b00, TSA_DEACTIVATED});
        r0 = rdr.n_reply;
        a0 = acc_n;
        for (int i = 1; i <= 9; i++) begin
            rdr.send(tsa_cmd_t'(i), tag_handle, 4'h1);
        end
        expect_idle("deactivated ignores", r0, a0, TSA_DEACTIVATED);
        @(negedge clock);
        field_ok = 1'b0;
        repeat (2) @(negedge clock);
        check("power loss", {2'b00, tag_state}, {2'b00, TSA_OFF});
        field_ok = 1'b1;
        repeat (2) @(negedge clock);
        check("power back", {2'b00, tag_state}, {2'b00, TSA_READY});
    endtask

    task automatic print_verdict();
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        t_field_off();
        t_power_up();
        t_open();
        t_rounds();
        t_selected();
        t_deselected();
        t_deactivated();
        print_verdict();
    end
endmodule // tb_tag_state_and_anticollision
`default_nettype wire

// [dv/tsa_reader_model.sv]
// Reader model: drives one decoded command at a time toward the tag and runs slot rounds.
// Assumes the bench calls its tasks from one process and the tag answers on reply_valid.
`timescale 1ns/1ps
`default_nettype none
module tsa_reader_model (
    input wire logic clock,
    input wire logic reply_valid,
    input wire logic [tsa_pkg::HANDLE_W-1:0] reply_handle,
    output logic cmd_valid,
    output tsa_pkg::tsa_cmd_t cmd_code,
    output logic [tsa_pkg::HANDLE_W-1:0] cmd_handle,
    output logic [tsa_pkg::NIBBLE_W-1:0] probe_slot_index
);
    import tsa_pkg::*;

    int n_reply = 0;
    logic [HANDLE_W-1:0] last_reply = 8'h00;

    // Quiet bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = TSA_CMD_NONE;
        cmd_handle = 8'h00;
        probe_slot_index = 4'h0;
    end

    // Counts tag answers and keeps the last handle heard
    always @(posedge clock) begin
        if (reply_valid === 1'b1) begin
            n_reply <= n_reply + 1;
            last_reply <= reply_handle;
        end
    end

    // One command for one cycle, then two quiet cycles for the answer to land
    task automatic send(input tsa_cmd_t code, input logic [7:0] h, input logic [3:0] idx);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_handle = h;
        probe_slot_index = idx;
        @(negedge clock);
        // Released arguments turn to their inverse so stale values are never trusted
        cmd_valid = 1'b0;
        cmd_code = tsa_cmd_t'(~code);
        cmd_handle = ~h;
        probe_slot_index = ~idx;
        repeat (2) @(negedge clock);
    endtask

    // Sixteen slots: zero probe first, then slot probes 1 to 15
    task automatic run_round(input bit pick, output int hits, output int hit_slot);
        int base;
        hits = 0;
        hit_slot = -1;
        for (int s = 0; s < 16; s++) begin
            base = n_reply;
            if (s == 0) begin
                send(TSA_CMD_SLOT_ZERO_PROBE, 8'h00, 4'h0);
            end else begin
                send(TSA_CMD_SLOT_PROBE, 8'h00, 4'(s));
            end
            // An answer is counted, and selected when pick is set, before the next slot
            if (n_reply != base) begin
                hits++;
                hit_slot = s;
                if (pick) begin
                    send(TSA_CMD_SELECT, last_reply, 4'h0);
                end
            end
        end
    endtask
endmodule // tsa_reader_model
`default_nettype wire
